//--- core/rnd_exc_entry.sv
// Operation
// - Warm reset request always takes soft reset.
// - Soft reset sets status, error PC, reset vector.
// - Delay slot subtracts adjustment from restart address.
// - Compressed ISA: adjustment four or two.
// - Compressed ISA: restart uses select bit, clears it.
// - Compact only: restart is PC, slot size.
// - Both ISAs: select bit restart, field three sets.
// - Single-step enable raises step exception each step.
// - No step exception right after debug return.
// - Step restart is next instruction, flag cleared.
// - Normal exceptions taken, then handler first step.
// - Breakpoint unaffected; step before points at it.
// - Step outranks all but reset kinds.
// - Steps allowed only when absent bit clear.
// - Break bit or pin raises debug interrupt.
// - Debug interrupt soon, restart PC, slot flag.
// - Nonmaskable input edge gives exactly one exception.
// - Nonmaskable taken at boundary, nothing else reset.
// - Nonmaskable sets select, flag, level; clears others.
// - Nonmaskable error PC minus four in slot.
// - Debug exceptions set debug mode, pick vector.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
module rnd_exc_entry #(
    parameter bit SINGLE_STEP_ABSENT = 1'b0 // Hardware lacks single-step when set.
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins from the system and debug controller, active high.
    input  wire logic        warm_reset_request,
    input  wire logic        nmi_request,
    input  wire logic        debug_interrupt_request,
    // Pipeline view of the current instruction.
    input  wire logic        instr_boundary,
    input  wire logic [31:0] current_pc,
    input  wire logic        in_delay_slot,
    input  wire logic        extended_compressed,
    input  wire logic [31:0] delay_slot_size,
    input  wire logic        step_done,
    input  wire logic        normal_exception,
    input  wire logic [31:0] next_pc,
    input  wire logic        debug_return_instruction,
    input  wire logic        software_breakpoint_instruction,
    // Redirect to the fetch unit.
    output logic             redirect_valid,
    output logic      [31:0] redirect_pc,
    output logic             instruction_set_select,
    output logic             debug_mode_flag
);
    // Synchronised pin levels.
    logic [2:0]  pin_level;
    logic        warm_lvl;                // Synchronised warm reset request.
    logic        nmi_lvl;                 // Synchronised nonmaskable request.
    logic        debug_interrupt_status_lvl;                // Synchronised debug interrupt request.
    logic        warm_prev_reg;           // Last warm reset level.
    logic        nmi_prev_reg;            // Last nonmaskable level.
    logic        nmi_pend_reg;            // Nonmaskable edge waiting for a boundary.
    logic        step_supp_reg;           // Step after debug return is suppressed.
    // Software visible state.
    logic [2:0]  control_reg;             // Control bits.
    logic [2:0]  config_reg;              // ISA configuration bits.
    logic [4:0]  status_reg;              // Status fields.
    logic [5:0]  debug_reg;               // Debug status bits.
    logic [31:0] error_pc_reg;            // Error restart PC.
    logic [31:0] debug_pc_reg;            // Debug restart PC.

    rnd_pin_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    ({debug_interrupt_request, nmi_request, warm_reset_request}),
        .level_out (pin_level)
    );
    assign warm_lvl = pin_level[0];
    assign nmi_lvl  = pin_level[1];
    assign debug_interrupt_status_lvl = pin_level[2];

    // Configuration decode.
    wire       cfg_ca    = config_reg[rnd_pkg::CFG_CA];
    wire [1:0] cfg_isa   = config_reg[rnd_pkg::CFG_ISA_LO +: 2];
    wire       sst_on    = control_reg[rnd_pkg::CTL_SST];
    wire       ptrap     = control_reg[rnd_pkg::CTL_PTRAP];
    wire       brk_req   = control_reg[rnd_pkg::CTL_BRK];
    wire       in_debug  = debug_reg[rnd_pkg::DBG_DM];

    // Exception requests in priority order.
    wire step_end  = step_done | normal_exception;
    // Soft reset is taken on each new assertion of the request and cannot be masked.
    wire take_soft = warm_lvl & ~warm_prev_reg;
    wire step_ok   = sst_on & ~in_debug & ~SINGLE_STEP_ABSENT & ~step_supp_reg;
    wire take_step = ~take_soft & step_ok & step_end;
    wire take_bp   = ~take_soft & ~take_step & ~in_debug & instr_boundary
                   & software_breakpoint_instruction;
    wire take_debug_interrupt_status = ~take_soft & ~take_step & ~take_bp & ~in_debug
                   & (brk_req | debug_interrupt_status_lvl);
    wire take_nmi  = ~take_soft & ~take_step & ~take_bp & ~take_debug_interrupt_status
                   & nmi_pend_reg & instr_boundary;
    wire take_dbg  = take_step | take_bp | take_debug_interrupt_status;
    wire nmi_edge  = nmi_lvl & ~nmi_prev_reg;

    // Restart address and delay slot adjustment for soft reset.
    logic [31:0] restart_address;
    logic [31:0] delay_slot_adjustment;
    logic        isa_next;
    always_comb begin
        restart_address       = current_pc;
        delay_slot_adjustment = rnd_pkg::ADJ_WORD;
        isa_next              = instruction_set_select;
        if (cfg_ca) begin
            // Compressed option: fold the select bit into bit zero.
            restart_address = {current_pc[31:1], instruction_set_select};
            if (!instruction_set_select || extended_compressed) begin
                delay_slot_adjustment = rnd_pkg::ADJ_WORD;
            end else begin
                delay_slot_adjustment = rnd_pkg::ADJ_HALF;
            end
            isa_next = 1'b0;
        end else if (cfg_isa == rnd_pkg::ISA_COMPACT) begin
            // Compact only: adjustment is the slot instruction size.
            restart_address       = current_pc;
            delay_slot_adjustment = delay_slot_size;
        end else if (cfg_isa > rnd_pkg::ISA_COMPACT) begin
            // Both ISAs present.
            restart_address = {current_pc[31:1], instruction_set_select};
            if (!instruction_set_select) begin
                delay_slot_adjustment = rnd_pkg::ADJ_WORD;
            end else begin
                delay_slot_adjustment = delay_slot_size;
            end
            isa_next = (cfg_isa == rnd_pkg::ISA_BOTH_C);
        end
    end
    wire [31:0] soft_err_pc = in_delay_slot ? restart_address - delay_slot_adjustment
                                            : restart_address;
    wire [31:0] nmi_err_pc  = in_delay_slot ? current_pc - rnd_pkg::ADJ_WORD
                                            : current_pc;
    wire [31:0] dbg_vec     = ptrap ? rnd_pkg::PROBE_VECTOR
                                    : rnd_pkg::DEBUG_VECTOR;

    // Debug restart PC: step points at the next instruction, breakpoint at the current one, debug interrupt at the current one or four back in a delay slot.
    wire [31:0] debug_interrupt_status_pc  = in_delay_slot ? current_pc - rnd_pkg::ADJ_WORD : current_pc;
    wire [31:0] dpc_next = take_step ? next_pc : (take_bp ? current_pc : debug_interrupt_status_pc);

    // APB decode; the slave answers in the first access cycle.
    wire apb_setup = psel & ~penable;
    wire apb_write = psel & penable & pready & pwrite;
    wire hit_ctl   = paddr == rnd_pkg::OFF_CONTROL;
    wire hit_cfg   = paddr == rnd_pkg::OFF_CONFIG;
    wire addr_ok   = hit_ctl | hit_cfg | (paddr == rnd_pkg::OFF_DEBUG)
                   | (paddr == rnd_pkg::OFF_STATUS) | (paddr == rnd_pkg::OFF_ERROR_PC)
                   | (paddr == rnd_pkg::OFF_DEBUG_PC);
    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            rnd_pkg::OFF_CONTROL:  rd_mux = {29'h0000_0000, control_reg};
            rnd_pkg::OFF_DEBUG:    rd_mux = {26'h000_0000, debug_reg};
            rnd_pkg::OFF_STATUS:   rd_mux = {27'h000_0000, status_reg};
            rnd_pkg::OFF_ERROR_PC: rd_mux = error_pc_reg;
            rnd_pkg::OFF_DEBUG_PC: rd_mux = debug_pc_reg;
            rnd_pkg::OFF_CONFIG:   rd_mux = {29'h0000_0000, config_reg};
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus answer: ready, error and read data are loaded in the setup cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~addr_ok;
            prdata  <= (apb_setup & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Control bits; hardware clears the break request only when it is taken,
    // and a software write of one in that same cycle keeps it set.
    logic [2:0] control_next;
    always_comb begin
        control_next = control_reg;
        if (take_debug_interrupt_status) begin
            control_next[rnd_pkg::CTL_BRK] = 1'b0;
        end
        if (apb_write && hit_ctl) begin
            control_next = pwdata[2:0] | (control_next & 3'h4);
            control_next[rnd_pkg::CTL_BRK] = pwdata[rnd_pkg::CTL_BRK]
                                           | (control_reg[rnd_pkg::CTL_BRK] & ~take_debug_interrupt_status);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_reg <= 3'h0;
            config_reg  <= rnd_pkg::CONFIG_RESET;
        end else begin
            control_reg <= control_next;
            if (apb_write && hit_cfg) begin
                config_reg <= pwdata[2:0];
            end
        end
    end

    // Edge detection and pending state for the pins and steps.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warm_prev_reg <= 1'b0;
            nmi_prev_reg  <= 1'b0;
            nmi_pend_reg  <= 1'b0;
            step_supp_reg <= 1'b0;
        end else begin
            warm_prev_reg <= warm_lvl;
            nmi_prev_reg  <= nmi_lvl;
            // A new edge wins over the clear of an earlier one.
            nmi_pend_reg  <= nmi_edge | (nmi_pend_reg & ~take_nmi);
            if (debug_return_instruction) begin
                step_supp_reg <= 1'b1;
            end else if (step_end) begin
                step_supp_reg <= 1'b0;
            end
        end
    end

    // Status fields and error restart PC for soft reset and nonmaskable entry.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg   <= rnd_pkg::STATUS_RESET;
            error_pc_reg <= 32'h0000_0000;
        end else if (take_soft) begin
            status_reg   <= rnd_pkg::STATUS_SOFT;
            error_pc_reg <= soft_err_pc;
        end else if (take_nmi) begin
            status_reg   <= rnd_pkg::STATUS_NMI;
            error_pc_reg <= nmi_err_pc;
        end
    end

    // Debug register and debug restart PC; debug return leaves debug mode.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            debug_reg    <= {1'b0, SINGLE_STEP_ABSENT, 4'h0};
            debug_pc_reg <= 32'h0000_0000;
        end else if (take_dbg) begin
            debug_reg[rnd_pkg::DBG_SS]   <= take_step;
            debug_reg[rnd_pkg::DBG_DEBUG_INTERRUPT_STATUS] <= take_debug_interrupt_status;
            debug_reg[rnd_pkg::DBG_BP]   <= take_bp;
            debug_reg[rnd_pkg::DBG_DBD]  <= take_debug_interrupt_status & in_delay_slot;
            debug_reg[rnd_pkg::DBG_DM]   <= 1'b1;
            debug_pc_reg                 <= dpc_next;
        end else if (debug_return_instruction) begin
            debug_reg[rnd_pkg::DBG_DM] <= 1'b0;
        end
    end

    // Redirect and instruction set select.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            redirect_valid         <= 1'b0;
            redirect_pc            <= rnd_pkg::RESET_VECTOR;
            instruction_set_select <= 1'b0;
            debug_mode_flag        <= 1'b0;
        end else begin
            redirect_valid  <= take_soft | take_nmi | take_dbg;
            debug_mode_flag <= take_dbg | (in_debug & ~debug_return_instruction);
            if (take_soft || take_nmi) begin
                redirect_pc <= rnd_pkg::RESET_VECTOR;
            end else if (take_dbg) begin
                redirect_pc <= dbg_vec;
            end
            if (take_soft) begin
                instruction_set_select <= isa_next;
            end
        end
    end

    // Checks on the entry behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_nmi_entry;
        take_nmi ##1 redirect_valid;
    endsequence

    chk_soft_reset_entry: assert property (take_soft |=> redirect_valid
        && redirect_pc == rnd_pkg::RESET_VECTOR && status_reg[rnd_pkg::ST_SR]
        && status_reg[rnd_pkg::ST_ERL])
        else $error("soft reset entry wrong");
    chk_reset_slot_pc: assert property (take_soft && in_delay_slot && !cfg_ca
        && cfg_isa == 2'h0 |=> error_pc_reg == $past(current_pc) - rnd_pkg::ADJ_WORD)
        else $error("soft reset delay slot error pc wrong");
    chk_step_raise: assert property (step_end && step_ok && !warm_lvl
        |=> debug_reg[rnd_pkg::DBG_SS] && debug_mode_flag && !debug_reg[rnd_pkg::DBG_DBD])
        else $error("single step not raised");
    chk_step_suppress: assert property (debug_return_instruction ##1 step_end
        && !debug_return_instruction |-> !take_step)
        else $error("step after debug return not suppressed");
    chk_step_absent: assert property (SINGLE_STEP_ABSENT |-> !take_step)
        else $error("single step while absent");
    chk_nmi_once: assert property (take_nmi |=> !nmi_pend_reg || $past(nmi_edge))
        else $error("nmi taken twice for one edge");
    chk_nmi_status: assert property (s_nmi_entry |-> status_reg == rnd_pkg::STATUS_NMI
        && redirect_pc == rnd_pkg::RESET_VECTOR)
        else $error("nmi status or vector wrong");
    chk_debug_vector: assert property (take_dbg |=> redirect_pc
        == ($past(ptrap) ? rnd_pkg::PROBE_VECTOR : rnd_pkg::DEBUG_VECTOR))
        else $error("debug vector wrong");
    chk_debug_interrupt_status_slot: assert property (take_debug_interrupt_status && in_delay_slot |=>
        debug_reg[rnd_pkg::DBG_DBD] && debug_pc_reg == $past(current_pc) - rnd_pkg::ADJ_WORD)
        else $error("debug interrupt slot flag wrong");

    // Further entry checks; the step entry is written as a two-step sequence.
    // All but chk_nmi_wait and chk_debug_hold compare the stored state one cycle after the take signal.
    sequence s_step_entry;
        take_step ##1 redirect_valid;
    endsequence

    chk_step_entry_pc: assert property (s_step_entry |->
        debug_pc_reg == $past(next_pc) && !debug_reg[rnd_pkg::DBG_DBD])
        else $error("single step restart pc wrong");
    chk_nmi_wait: assert property (nmi_pend_reg && !instr_boundary && !take_soft
        && !take_dbg |=> !redirect_valid)
        else $error("nmi taken off a boundary");
    chk_nmi_error_pc: assert property (take_nmi |=> error_pc_reg
        + ($past(in_delay_slot) ? rnd_pkg::ADJ_WORD : '0) == $past(current_pc))
        else $error("nmi error pc wrong");
    chk_isa_select: assert property (take_soft && !cfg_ca
        && cfg_isa > rnd_pkg::ISA_COMPACT |=> instruction_set_select
        == $past(cfg_isa == rnd_pkg::ISA_BOTH_C))
        else $error("instruction set select wrong after soft reset");
    chk_brk_clear: assert property (take_debug_interrupt_status && !(apb_write && hit_ctl)
        |=> !control_reg[rnd_pkg::CTL_BRK])
        else $error("break request not cleared");
    chk_debug_hold: assert property (in_debug && !debug_return_instruction
        |=> $stable(debug_pc_reg))
        else $error("debug restart pc moved in debug mode");
    chk_debug_interrupt_status_plain: assert property (take_debug_interrupt_status && !in_delay_slot |=>
        !debug_reg[rnd_pkg::DBG_DBD] && debug_pc_reg == $past(current_pc))
        else $error("debug interrupt restart pc wrong");
endmodule // rnd_exc_entry

//--- core/rnd_pin_sync.sv
// Three-stage pin synchroniser; the output moves only when stages one and two agree.
module rnd_pin_sync #(
    parameter int WIDTH = 3 // Number of pins handled.
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    genvar g;
    // One independent chain per pin.
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic [rnd_pkg::SYNC_DEPTH-1:0] stage_reg; // Stage zero is read by stage one only.
            // Shift the pin through the chain and accept agreeing values.
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage_reg    <= '0;
                    level_out[g] <= 1'b0;
                end else begin
                    stage_reg <= {stage_reg[1:0], pin_in[g]};
                    if (stage_reg[1] == stage_reg[2]) begin
                        level_out[g] <= stage_reg[2];
                    end
                end
            end
        end
    endgenerate
endmodule // rnd_pin_sync

//--- core/rnd_pkg.sv
// Constants shared by the exception entry unit and its pin synchroniser.
package rnd_pkg;
    // APB register byte offsets.
    localparam logic [7:0] OFF_CONTROL   = 8'h00; // Single-step, probe trap, break request.
    localparam logic [7:0] OFF_DEBUG     = 8'h04; // Debug status bits, read only.
    localparam logic [7:0] OFF_STATUS    = 8'h08; // Status fields, read only.
    localparam logic [7:0] OFF_ERROR_PC  = 8'h0C; // Error restart PC, read only.
    localparam logic [7:0] OFF_DEBUG_PC  = 8'h10; // Debug restart PC, read only.
    localparam logic [7:0] OFF_CONFIG    = 8'h14; // ISA configuration, read/write.
    // Control register bit positions.
    localparam int CTL_SST    = 0; // Single-step enable.
    localparam int CTL_PTRAP  = 1; // Probe trap select.
    localparam int CTL_BRK    = 2; // Debug break request.
    // Debug register bit positions.
    localparam int DBG_SS     = 0; // Single-step status.
    localparam int DBG_DEBUG_INTERRUPT_STATUS   = 1; // Debug interrupt status.
    localparam int DBG_DBD    = 2; // Debug delay slot flag.
    localparam int DBG_DM     = 3; // Debug mode flag.
    localparam int DBG_ABSENT = 4; // Single-step absent.
    localparam int DBG_BP     = 5; // Software breakpoint status.
    // Status register bit positions.
    localparam int ST_BEV     = 0; // Boot vector select.
    localparam int ST_TS      = 1; // TLB shutdown flag.
    localparam int ST_SR      = 2; // Soft reset flag.
    localparam int ST_NMI     = 3; // Nonmaskable flag.
    localparam int ST_ERL     = 4; // Error level.
    // Config register bit positions.
    localparam int CFG_CA     = 0; // Compressed ISA present.
    localparam int CFG_ISA_LO = 1; // Low bit of the ISA configuration field.
    // Vectors.
    localparam logic [31:0] RESET_VECTOR = 32'hBFC0_0000; // Reset and NMI entry.
    localparam logic [31:0] DEBUG_VECTOR = 32'hBFC0_0480; // Normal debug entry.
    localparam logic [31:0] PROBE_VECTOR = 32'hFF20_0200; // Probe trap debug entry.
    // Delay slot adjustments and ISA field codes.
    localparam logic [31:0] ADJ_WORD     = 32'h0000_0004; // 32-bit delay slot.
    localparam logic [31:0] ADJ_HALF     = 32'h0000_0002; // 16-bit delay slot.
    localparam logic [1:0]  ISA_COMPACT  = 2'h1; // Only the compact ISA.
    localparam logic [1:0]  ISA_BOTH_C   = 2'h3; // Both, compact on exception.
    // Reset values.
    localparam logic [4:0]  STATUS_RESET = 5'h11; // Boot vector select and error level.
    localparam logic [2:0]  CONFIG_RESET = 3'h0;  // No compressed ISA.
    // Status values written on entry.
    localparam logic [4:0]  STATUS_SOFT  = 5'h15; // Boot vector select, soft reset, error level.
    localparam logic [4:0]  STATUS_NMI   = 5'h19; // Boot vector select, nonmaskable, error level.
    // Pin synchroniser depth.
    localparam int SYNC_DEPTH = 3;
endpackage : rnd_pkg

//--- sim/rnd_exc_entry_tb.sv
// Self-checking bench for the exception entry unit.
module rnd_exc_entry_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rpc, cpc = 32'h0, npc = 32'h0, rd;
    logic pready, pslverr, rv, iss, dmf, wr, nmi, debug_interrupt_status, err;
    logic slot = 0, sdone = 0, dret = 0, nexc = 0, bnd = 1;
    int n_fail = 0, num_checks = 0, cnt;
    rnd_sys_model sys (.clk(clk), .warm_reset_request(wr), .nmi_request(nmi),
        .debug_interrupt_request(debug_interrupt_status));
    rnd_exc_entry dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .warm_reset_request(wr), .nmi_request(nmi),
        .debug_interrupt_request(debug_interrupt_status), .instr_boundary(bnd), .current_pc(cpc),
        .in_delay_slot(slot), .extended_compressed(1'b0), .delay_slot_size(32'h0000_0004),
        .step_done(sdone), .normal_exception(nexc), .next_pc(npc),
        .debug_return_instruction(dret), .software_breakpoint_instruction(1'b0),
        .redirect_valid(rv), .redirect_pc(rpc), .instruction_set_select(iss),
        .debug_mode_flag(dmf));
    // Free-running 125 MHz core clock.
    initial begin
        forever #4 clk = ~clk;
    end
    // Compares one 32-bit result and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Counts redirect pulses over n cycles; keeps the last target in rd.
    task automatic watch(input int n);
        cnt = 0;
        repeat (n) begin
            @(negedge clk);
            if (rv === 1'b1) begin
                cnt++;
                rd = rpc;
            end
        end
    endtask
    // Soft reset from a compressed-ISA delay slot, then NMI from a delay slot held long.
    task automatic t_resets;
        apb(1, rnd_pkg::OFF_CONFIG, 32'h1);
        cpc <= 32'h0000_1000;
        slot <= 1'b1;
        fork
            sys.pulse(0, 20);
            watch(12);
        join
        chk(cnt, 1);
        chk(rd, rnd_pkg::RESET_VECTOR);
        apb(0, rnd_pkg::OFF_ERROR_PC, 32'h0);
        chk(rd, 32'h0000_0FFC);
        apb(0, rnd_pkg::OFF_STATUS, 32'h0);
        chk(rd, 32'h15);
        cpc <= 32'h0000_2000;
        bnd <= 1'b0;
        fork
            sys.pulse(1, 30);
            watch(20);
        join
        chk(cnt, 0);
        bnd <= 1'b1;
        watch(4);
        chk(cnt, 1);
        apb(0, rnd_pkg::OFF_ERROR_PC, 32'h0);
        chk(rd, 32'h0000_1FFC);
        apb(0, rnd_pkg::OFF_STATUS, 32'h0);
        chk(rd, 32'h19);
        // Both ISAs with field three: select bit set after entry.
        apb(1, rnd_pkg::OFF_CONFIG, 32'h6);
        cpc <= 32'h0000_4000;
        fork
            sys.pulse(0, 8);
            watch(12);
        join
        chk({31'h0, iss}, 32'h1);
        apb(0, rnd_pkg::OFF_ERROR_PC, 32'h0);
        chk(rd, 32'h0000_3FFC);
        // Plain 32-bit configuration from a delay slot: restart is the PC minus four.
        apb(1, rnd_pkg::OFF_CONFIG, 32'h0);
        cpc <= 32'h0000_5000;
        fork
            sys.pulse(0, 8);
            watch(12);
        join
        apb(0, rnd_pkg::OFF_ERROR_PC, 32'h0);
        chk(rd, 32'h0000_4FFC);
        slot <= 1'b0;
        $display("test resets done");
    endtask
    // Break request, debug return, suppressed first step, then a real step.
    task automatic t_debug;
        cpc <= 32'h0000_3000;
        apb(1, rnd_pkg::OFF_CONTROL, 32'h4);
        watch(8);
        chk(rd, rnd_pkg::DEBUG_VECTOR);
        chk({31'h0, dmf}, 32'h1);
        apb(0, rnd_pkg::OFF_DEBUG_PC, 32'h0);
        chk(rd, 32'h0000_3000);
        apb(0, rnd_pkg::OFF_DEBUG, 32'h0);
        chk(rd & 32'hE, 32'hA);
        apb(1, rnd_pkg::OFF_CONTROL, 32'h1);
        @(posedge clk) dret <= 1'b1;
        @(posedge clk) {dret, sdone, npc} <= {1'b0, 1'b1, 32'h0000_3004};
        @(posedge clk) sdone <= 1'b0;
        watch(6);
        chk(cnt, 0);
        @(posedge clk) {sdone, npc} <= {1'b1, 32'h0000_3008};
        @(posedge clk) sdone <= 1'b0;
        watch(6);
        chk(cnt, 1);
        apb(0, rnd_pkg::OFF_DEBUG_PC, 32'h0);
        chk(rd, 32'h0000_3008);
        apb(0, rnd_pkg::OFF_DEBUG, 32'h0);
        chk(rd & 32'h5, 32'h1);
        // Leave debug mode, then raise the debug interrupt pin from a delay slot.
        @(posedge clk) dret <= 1'b1;
        @(posedge clk) {dret, slot, cpc} <= {1'b0, 1'b1, 32'h0000_6000};
        fork
            sys.pulse(2, 8);
            watch(16);
        join
        chk(cnt, 1);
        apb(0, rnd_pkg::OFF_DEBUG_PC, 32'h0);
        chk(rd, 32'h0000_5FFC);
        apb(0, rnd_pkg::OFF_DEBUG, 32'h0);
        chk(rd & 32'h7, 32'h6);
        // Leave again; the first step is suppressed, then a normal exception steps.
        @(posedge clk) {dret, slot} <= 2'b10;
        @(posedge clk) {dret, sdone} <= 2'b01;
        @(posedge clk) {sdone, nexc, npc} <= {1'b0, 1'b1, 32'h0000_7000};
        @(posedge clk) nexc <= 1'b0;
        watch(6);
        chk(cnt, 1);
        apb(0, rnd_pkg::OFF_DEBUG_PC, 32'h0);
        chk(rd, 32'h0000_7000);
        apb(0, 8'h3C, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test debug done");
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence after a 12-cycle reset.
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        chk(rpc, rnd_pkg::RESET_VECTOR);
        apb(0, rnd_pkg::OFF_STATUS, 32'h0);
        chk(rd, {27'h0, rnd_pkg::STATUS_RESET});
        t_resets();
        t_debug();
        print_verdict();
    end
    // Cuts a hang short well beyond the expected few hundred cycles.
    initial begin
        #40000;
        n_fail++;
        print_verdict();
    end
endmodule // rnd_exc_entry_tb

//--- sim/rnd_sys_model.sv
// Model of the system reset, interrupt source and debug controller pins.
module rnd_sys_model (
    input  wire logic clk,
    output logic      warm_reset_request,
    output logic      nmi_request,
    output logic      debug_interrupt_request
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] pin_reg; // Bit 0 warm reset, bit 1 NMI, bit 2 debug interrupt.
    assign {debug_interrupt_request, nmi_request, warm_reset_request} = pin_reg;
    // All pins idle low until a pulse is asked for.
    initial begin
        pin_reg = 3'h0;
    end
    // Raises one pin for len cycles, then drops it so a later request is a new edge.
    task automatic pulse(input int which, input int len);
        @(posedge clk);
        pin_reg[which] <= 1'b1;
        repeat (len) @(posedge clk);
        pin_reg[which] <= 1'b0;
    endtask
endmodule // rnd_sys_model
